//--- design/aoc_top.sv
/*
 Offset calibration, black-level feedback, lead-in control and output coding for a
 10-bit imaging converter, with a plain register port.
 Assumes adc_sample is on core_clk; the two timing pins are asynchronous.
*/
`timescale 1ns/1ns
// Function
// - Calibration starts when register reset mode clears, lasts exactly 40000 cycles.
// - Offset DAC gets calibration result plus programmed clamp level 14 to 76.
// - In each black window after calibration ends, measure output and correct toward the black reference.
// - One feedback interval per optical-black pulse; computation inside the window.
// - A changed second-stage gain write enters high-speed lead-in mode.
// - Lead-in gain field selects multiplier 4, 8, 16 or 32.
// - Stay in lead-in while error exceeds 16; else return after selected lines.
// - Cancel field selects return delay of 1, 2, 4 or 8 lines.
// - Pre-blank isolates the input and forces output to the clamp code.
// - Standby floats all output bits and enters low power, overriding all.
// - Gray select low gives straight binary output.
// - Gray select high gives reflected Gray code of the result.
// - Top invert alone inverts only output bit 9.
// - Low invert flips bits 8 to 0; both flip all ten.
// - Pre-blank overrides code selection and inversion.
// - Test pattern without standby drives 1010101010 regardless of other settings.
module aoc_top
	import aoc_pkg::*;
#(
	parameter int CAL_LEN  = CAL_CYCLES,
	parameter int FB_SHIFT = FB_SHIFT_DEF
)
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_we,
	input  wire logic        reg_re,
	output logic      [15:0] reg_rdata,
	// Converter result
	input  wire logic [9:0]  adc_sample,
	// Timing pins
	input  wire logic        preblank_input,
	input  wire logic        optical_black_pulse,
	// Sample output
	output logic      [9:0]  dout,
	output logic             dout_oe,
	// Analog controls and status
	output logic      [10:0] offset_dac,
	output logic      [15:0] black_fb,
	output logic             sample_isolate,
	output logic             low_power,
	output logic             cal_active,
	output logic             leadin_active
);
	localparam logic [15:0] CAL_LAST = 16'(CAL_LEN - 1);

	logic [5:0]         ctrl_r;
	logic [6:0]         clamp_r;
	logic [6:0]         clamp_nxt;
	logic [7:0]         gain_r;
	logic [3:0]         leadin_r;
	logic [15:0]        rdata_r;
	logic [15:0]        rdata_nxt;
	logic               pb_m;
	logic               pb_s;
	logic               obp_m;
	logic               obp_s;
	logic               obp_d;
	logic               line_tick;
	logic [15:0]        cal_cnt_r;
	logic               cal_active_r;
	logic signed [7:0]  cal_res_r;
	logic [10:0]        dac_sum;
	logic [10:0]        offset_dac_r;
	logic [3:0]         ob_cnt_r;
	logic               fb_apply;
	logic signed [10:0] err;
	logic signed [10:0] err_abs;
	logic signed [15:0] err_ext;
	logic [2:0]         shamt;
	logic signed [15:0] step;
	logic signed [15:0] black_fb_r;
	logic               err_big_r;
	logic               gain_chg;
	logic               lead_act;
	logic               leadin_active_r;
	aoc_out_ctl_t       out_ctl;
	logic [9:0]         fmt_code;
	logic               fmt_drive;
	logic [9:0]         dout_r;
	logic               dout_oe_r;
	logic               sample_isolate_r;

	////////////////////////////////////////////////////////////////////////////////
	// Register port

	always_comb
	begin
		if (reg_wdata < {9'h000, CLAMP_MIN})
			clamp_nxt = CLAMP_MIN;
		else if (reg_wdata > {9'h000, CLAMP_MAX})
			clamp_nxt = CLAMP_MAX;
		else
			clamp_nxt = reg_wdata[6:0];
	end

	assign gain_chg = reg_we && reg_addr == REG_GAIN && reg_wdata[7:0] != gain_r;

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			ctrl_r   <= CTRL_RST;
			clamp_r  <= CLAMP_RST;
			gain_r   <= GAIN_RST;
			leadin_r <= LEADIN_RST;
		end
		else if (reg_we)
		begin
			case (reg_addr)
				REG_CTRL:   ctrl_r   <= reg_wdata[5:0];
				REG_CLAMP:  clamp_r  <= clamp_nxt;
				REG_GAIN:   gain_r   <= reg_wdata[7:0];
				REG_LEADIN: leadin_r <= reg_wdata[3:0];
				default:    ;
			endcase
		end
	end

	always_comb
	begin
		case (reg_addr)
			REG_CTRL:   rdata_nxt = {10'h000, ctrl_r};
			REG_CLAMP:  rdata_nxt = {9'h000, clamp_r};
			REG_GAIN:   rdata_nxt = {8'h00, gain_r};
			REG_LEADIN: rdata_nxt = {12'h000, leadin_r};
			REG_STATUS: rdata_nxt = {13'h0000, err_big_r, leadin_active_r, cal_active_r};
			REG_CALRES: rdata_nxt = {{8{cal_res_r[7]}}, cal_res_r};
			REG_FBVAL:  rdata_nxt = black_fb_r;
			REG_DAC:    rdata_nxt = {{5{offset_dac_r[10]}}, offset_dac_r};
			default:    rdata_nxt = 16'h0000;
		endcase
	end

	// Data only in the cycle after the strobe, zero otherwise
	always_ff @(posedge core_clk)
	begin
		if (rst)
			rdata_r <= 16'h0000;
		else
			rdata_r <= reg_re ? rdata_nxt : 16'h0000;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			pb_m  <= 1'b0;
			pb_s  <= 1'b0;
			obp_m <= 1'b0;
			obp_s <= 1'b0;
			obp_d <= 1'b0;
		end
		else
		begin
			pb_m  <= preblank_input;
			pb_s  <= pb_m;
			obp_m <= optical_black_pulse;
			obp_s <= obp_m;
			obp_d <= obp_s;
		end
	end

	assign line_tick = obp_s && !obp_d;

	////////////////////////////////////////////////////////////////////////////////
	// Offset calibration

	// Reset mode keeps the counter parked; release starts a fresh run
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			cal_cnt_r    <= 16'h0000;
			cal_active_r <= 1'b1;
			cal_res_r    <= 8'sh00;
		end
		else if (ctrl_r[CTRL_RESET_MODE])
		begin
			cal_cnt_r    <= 16'h0000;
			cal_active_r <= 1'b1;
			cal_res_r    <= 8'sh00;
		end
		else if (cal_active_r)
		begin
			if (cal_cnt_r == CAL_LAST)
				cal_active_r <= 1'b0;
			else
				cal_cnt_r <= cal_cnt_r + 16'h0001;
			if (adc_sample > {3'h0, clamp_r} && cal_res_r != CAL_MIN)
				cal_res_r <= cal_res_r - 8'sh01;
			else if (adc_sample < {3'h0, clamp_r} && cal_res_r != CAL_MAX)
				cal_res_r <= cal_res_r + 8'sh01;
		end
	end

	assign dac_sum = {{3{cal_res_r[7]}}, cal_res_r} + {4'h0, clamp_r};

	always_ff @(posedge core_clk)
	begin
		// Reset value equals the sum of the reset operands, so the DAC never jumps
		if (rst)
			offset_dac_r <= {4'h0, CLAMP_RST};
		else
			offset_dac_r <= dac_sum;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Black-level feedback

	assign err     = $signed({1'b0, adc_sample} - {4'h0, clamp_r});
	assign err_abs = err[10] ? -err : err;
	assign err_ext = {{5{err[10]}}, err};
	assign shamt   = lead_act ? LEAD_SHIFT + {1'b0, leadin_r[1:0]} : 3'h0;
	// Lead-in multiplies before the shift so small errors still move the loop
	assign step    = (err_ext <<< shamt) >>> FB_SHIFT;
	// A settle delay lets the clamp level reach the output before it is sampled
	assign fb_apply = obp_s && ob_cnt_r == OB_SETTLE && !cal_active_r;

	always_ff @(posedge core_clk)
	begin
		if (rst)
			ob_cnt_r <= 4'h0;
		else if (!obp_s)
			ob_cnt_r <= 4'h0;
		else if (ob_cnt_r != 4'hf)
			ob_cnt_r <= ob_cnt_r + 4'h1;
	end

	// No saturation: a runaway loop wraps, so keep loop gain low
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			black_fb_r <= 16'sh0000;
			err_big_r  <= 1'b0;
		end
		else if (fb_apply)
		begin
			black_fb_r <= black_fb_r - step;
			err_big_r  <= err_abs > ERR_LIMIT;
		end
	end

	aoc_leadin u_leadin (
		.core_clk   (core_clk),
		.rst        (rst),
		.line_tick  (line_tick),
		.gain_chg   (gain_chg),
		.err_big    (err_big_r),
		.cancel_sel (leadin_r[3:2]),
		.active     (lead_act)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Output stage

	assign out_ctl = '{standby: ctrl_r[CTRL_STANDBY], pattern: ctrl_r[CTRL_PATTERN],
		gray: ctrl_r[CTRL_GRAY], low_inv: ctrl_r[CTRL_LOW_INV], top_inv: ctrl_r[CTRL_TOP_INV]};

	aoc_out_fmt u_fmt (
		.sample   (adc_sample),
		.ctl      (out_ctl),
		.preblank (pb_s),
		.clamp    (clamp_r),
		.code     (fmt_code),
		.drive    (fmt_drive)
	);

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			dout_r           <= 10'h000;
			dout_oe_r        <= 1'b0;
			sample_isolate_r <= 1'b0;
			leadin_active_r  <= 1'b0;
		end
		else
		begin
			dout_r           <= fmt_code;
			dout_oe_r        <= fmt_drive;
			sample_isolate_r <= pb_s;
			leadin_active_r  <= lead_act;
		end
	end

	assign reg_rdata      = rdata_r;
	assign dout           = dout_r;
	assign dout_oe        = dout_oe_r;
	assign offset_dac     = offset_dac_r;
	assign black_fb       = black_fb_r;
	assign sample_isolate = sample_isolate_r;
	assign low_power      = ctrl_r[CTRL_STANDBY];
	assign cal_active     = cal_active_r;
	assign leadin_active  = leadin_active_r;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	cal_length_a: assert property (@(posedge core_clk) disable iff (rst) $fell(cal_active_r) |-> $past(cal_cnt_r) == CAL_LAST && !$past(ctrl_r[CTRL_RESET_MODE])) else $error("calibration length wrong");
	dac_sum_a: assert property (@(posedge core_clk) disable iff (rst) ($stable(cal_res_r) && $stable(clamp_r)) |-> offset_dac_r == ({{3{cal_res_r[7]}}, cal_res_r} + {4'h0, clamp_r})) else $error("offset dac not cal plus clamp");
	fb_once_a: assert property (@(posedge core_clk) disable iff (rst) (black_fb_r != $past(black_fb_r)) |-> $past(obp_s) && $past(ob_cnt_r) == OB_SETTLE) else $error("feedback outside window");
	fb_hold_a: assert property (@(posedge core_clk) disable iff (rst) cal_active_r |=> $stable(black_fb_r)) else $error("feedback moved during calibration");
	standby_hiz_a: assert property (@(posedge core_clk) disable iff (rst) ctrl_r[CTRL_STANDBY] |=> !dout_oe_r) else $error("output driven in standby");
	pattern_out_a: assert property (@(posedge core_clk) disable iff (rst) (ctrl_r[CTRL_PATTERN] && !ctrl_r[CTRL_STANDBY]) |=> dout_r == 10'h2aa && dout_oe_r) else $error("test pattern wrong");
	preblank_out_a: assert property (@(posedge core_clk) disable iff (rst) (pb_s && !ctrl_r[CTRL_PATTERN] && !ctrl_r[CTRL_STANDBY]) |=> dout_r == {3'h0, $past(clamp_r)}) else $error("pre-blank not clamp");
	binary_out_a: assert property (@(posedge core_clk) disable iff (rst) (ctrl_r[5:1] == 5'h00 && !pb_s) |=> dout_r == $past(adc_sample)) else $error("binary output wrong");
	gray_out_a: assert property (@(posedge core_clk) disable iff (rst) (ctrl_r[5:1] == 5'h04 && !pb_s) |=> dout_r == ($past(adc_sample) ^ ($past(adc_sample) >> 1))) else $error("gray output wrong");
	top_inv_a: assert property (@(posedge core_clk) disable iff (rst) (ctrl_r[5:1] == 5'h10 && !pb_s) |=> dout_r == {~$past(adc_sample[9]), $past(adc_sample[8:0])}) else $error("top invert wrong");
	low_inv_a: assert property (@(posedge core_clk) disable iff (rst) (ctrl_r[5:1] == 5'h08 && !pb_s) |=> dout_r == {$past(adc_sample[9]), ~$past(adc_sample[8:0])}) else $error("low invert wrong");
endmodule

//--- design/aoc_pkg.sv
/*
 Constants, register map and types shared by the offset and output control block.
 Assumes one conversion clock for all logic.
*/
package aoc_pkg;
	localparam int CLK_PERIOD_NS = 50;
	localparam int CAL_TIME_NS   = 2000000;
	localparam int CAL_CYCLES    = CAL_TIME_NS / CLK_PERIOD_NS;
	localparam int FB_SHIFT_DEF  = 6;
	localparam int ADDR_W        = 8;
	localparam int DATA_W        = 16;
	localparam int SMP_W         = 10;
	localparam int FB_W          = 16;

	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_CLAMP  = 8'h04;
	localparam logic [7:0] REG_GAIN   = 8'h08;
	localparam logic [7:0] REG_LEADIN = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_CALRES = 8'h14;
	localparam logic [7:0] REG_FBVAL  = 8'h18;
	localparam logic [7:0] REG_DAC    = 8'h1c;

	localparam int CTRL_RESET_MODE = 0;
	localparam int CTRL_STANDBY    = 1;
	localparam int CTRL_PATTERN    = 2;
	localparam int CTRL_GRAY       = 3;
	localparam int CTRL_LOW_INV    = 4;
	localparam int CTRL_TOP_INV    = 5;
	localparam int LI_GAIN_LSB     = 0;
	localparam int LI_CANCEL_LSB   = 2;
	localparam int ST_CAL          = 0;
	localparam int ST_LEAD         = 1;
	localparam int ST_ERRBIG       = 2;

	localparam logic [5:0] CTRL_RST   = 6'h00;
	localparam logic [6:0] CLAMP_MIN  = 7'h0e;
	localparam logic [6:0] CLAMP_MAX  = 7'h4c;
	localparam logic [6:0] CLAMP_RST  = 7'h20;
	localparam logic [7:0] GAIN_RST   = 8'h00;
	localparam logic [3:0] LEADIN_RST = 4'h0;

	localparam logic signed [10:0] ERR_LIMIT  = 11'sh010;
	localparam logic [2:0]         LEAD_SHIFT = 3'h2;
	localparam logic signed [7:0]  CAL_MAX    = 8'sh7f;
	localparam logic signed [7:0]  CAL_MIN    = 8'sh81;
	localparam logic [9:0]         PATTERN    = 10'h2aa;
	localparam logic [3:0]         OB_SETTLE  = 4'h3;

	typedef struct packed {
		logic standby;
		logic pattern;
		logic gray;
		logic low_inv;
		logic top_inv;
	} aoc_out_ctl_t;
endpackage

//--- design/aoc_out_fmt.sv
/*
 Output code selection: standby, test pattern, pre-blank clamp, binary or Gray, inversion.
 Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ns
module aoc_out_fmt
	import aoc_pkg::*;
(
	// Inputs
	input  logic [9:0]   sample,
	input  aoc_out_ctl_t ctl,
	input  logic         preblank,
	input  logic [6:0]   clamp,
	// Result
	output logic [9:0]   code,
	output logic         drive
);
	logic [9:0] coded;

	always_comb
	begin
		coded = ctl.gray ? (sample ^ (sample >> 1)) : sample;
		code  = 10'h000;
		drive = 1'b0;
		if (ctl.standby)
		begin
			code  = 10'h000;
			drive = 1'b0;
		end
		else if (ctl.pattern)
		begin
			code  = PATTERN;
			drive = 1'b1;
		end
		else if (preblank)
		begin
			code  = {3'h0, clamp};
			drive = 1'b1;
		end
		else
		begin
			code  = coded ^ {ctl.top_inv, {9{ctl.low_inv}}};
			drive = 1'b1;
		end
	end
endmodule

//--- design/aoc_leadin.sv
/*
 High-speed lead-in sequencer, stepped once per optical-black line.
 Assumes line_tick is a one-cycle pulse per line and err_big holds the last line's error.
*/
`timescale 1ns/1ns
module aoc_leadin
	import aoc_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// Events
	input  wire logic       line_tick,
	input  wire logic       gain_chg,
	input  wire logic       err_big,
	input  wire logic [1:0] cancel_sel,
	// State
	output logic            active
);
	typedef enum logic [1:0] {LI_IDLE, LI_LEAD, LI_CANCEL} aoc_li_state_t;

	aoc_li_state_t st_r;
	logic [3:0]    cnt_r;
	logic [3:0]    delay;

	assign delay  = 4'h1 << cancel_sel;
	assign active = (st_r != LI_IDLE);

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			st_r  <= LI_IDLE;
			cnt_r <= 4'h0;
		end
		else if (gain_chg)
		begin
			st_r  <= LI_LEAD;
			cnt_r <= 4'h0;
		end
		else if (line_tick)
		begin
			case (st_r)
				LI_LEAD:
				begin
					cnt_r <= 4'h0;
					if (!err_big)
						st_r <= LI_CANCEL;
				end
				LI_CANCEL:
				begin
					if (err_big)
					begin
						st_r  <= LI_LEAD;
						cnt_r <= 4'h0;
					end
					else if (cnt_r + 4'h1 == delay)
					begin
						st_r  <= LI_IDLE;
						cnt_r <= 4'h0;
					end
					else
						cnt_r <= cnt_r + 4'h1;
				end
				default:
					cnt_r <= 4'h0;
			endcase
		end
	end

	lead_enter_a: assert property (@(posedge core_clk) disable iff (rst) gain_chg |=> st_r == LI_LEAD) else $error("gain change did not start lead-in");
	lead_hold_a: assert property (@(posedge core_clk) disable iff (rst) (st_r == LI_LEAD && err_big && !gain_chg) |=> st_r == LI_LEAD) else $error("lead-in left with large error");
	cancel_end_a: assert property (@(posedge core_clk) disable iff (rst) (st_r == LI_CANCEL && line_tick && !err_big && !gain_chg && cnt_r == delay - 4'h1) |=> st_r == LI_IDLE) else $error("cancel delay wrong");
	cancel_early_a: assert property (@(posedge core_clk) disable iff (rst) (st_r == LI_CANCEL && !gain_chg && cnt_r + 4'h1 < delay) |=> st_r != LI_IDLE) else $error("lead-in ended early");
endmodule

//--- tb/aoc_dsp_model.sv
/*
 Receiving signal processor model: watches the ten output pins each conversion clock.
 Assumes dout and dout_oe come straight from the block's registered outputs.
*/
`timescale 1ns/1ns
module aoc_dsp_model
(
	// Conversion clock
	input  wire logic       core_clk,
	// Output pins of the converter
	input  wire logic [9:0] dout,
	input  wire logic       dout_oe,
	// What the receiver sees
	output logic      [9:0] pin_level,
	output logic            floating
);
	logic [9:0] last_code_r;

	////////////////////////////////////////////////////////////////////////////////
	// Undriven pins have no pull, so never show the old code there
	assign floating  = ~dout_oe;
	assign pin_level = dout_oe ? dout : ~last_code_r;

	always_ff @(posedge core_clk)
	begin
		if (dout_oe)
			last_code_r <= dout;
	end
endmodule

//--- tb/tb_top.sv
/*
 Self-checking bench for the offset and output control block, driving its register port.
 Assumes calibration and feedback shift are shortened through the top's parameters.
*/
`timescale 1ns/1ns
module tb_top;
	import aoc_pkg::*;
	localparam int CAL_SIM   = 50;
	localparam int SHIFT_SIM = 2;

	logic        core_clk;
	logic        rst;
	logic [7:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_we;
	logic        reg_re;
	logic [15:0] reg_rdata;
	logic [9:0]  adc_sample;
	logic        preblank_input;
	logic        optical_black_pulse;
	logic [9:0]  dout;
	logic        dout_oe;
	logic [10:0] offset_dac;
	logic [15:0] black_fb;
	logic        sample_isolate;
	logic        low_power;
	logic        cal_active;
	logic        leadin_active;
	logic [9:0]  pin_level;
	logic        floating;
	int          err_count;
	int          n_tests;
	int          cycles;

	aoc_top #(.CAL_LEN(CAL_SIM), .FB_SHIFT(SHIFT_SIM)) aoc_top_i (
		.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .adc_sample(adc_sample),
		.preblank_input(preblank_input), .optical_black_pulse(optical_black_pulse),
		.dout(dout), .dout_oe(dout_oe), .offset_dac(offset_dac), .black_fb(black_fb),
		.sample_isolate(sample_isolate), .low_power(low_power), .cal_active(cal_active),
		.leadin_active(leadin_active));

	aoc_dsp_model aoc_dsp_model_i (.core_clk(core_clk), .dout(dout), .dout_oe(dout_oe),
		.pin_level(pin_level), .floating(floating));

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	task automatic finish_test;
		$display("Compares %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Run is about 470 cycles; a hang stops well short of forever
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			err_count++;
			finish_test();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_we    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_we <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
		@(posedge core_clk);
		reg_re   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_re <= 1'b0;
		#1;
		check(reg_rdata, exp);
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic set_sample(input logic [9:0] s);
		@(posedge core_clk);
		adc_sample <= s;
	endtask

	// One black-level line: window high 8 cycles, then low 8
	task automatic ob_line;
		@(posedge core_clk);
		optical_black_pulse <= 1'b1;
		repeat (8) @(posedge core_clk);
		optical_black_pulse <= 1'b0;
		wait_cyc(8);
	endtask

	function automatic logic [9:0] exp_code(input logic [9:0] s, input logic [2:0] m);
		logic [9:0] c;
		c = m[0] ? (s ^ (s >> 1)) : s;
		return c ^ {m[2], {9{m[1]}}};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		rst                 = 1'b1;
		reg_addr            = 8'h00;
		reg_wdata           = 16'h0000;
		reg_we              = 1'b0;
		reg_re              = 1'b0;
		adc_sample          = 10'h020;
		preblank_input      = 1'b0;
		optical_black_pulse = 1'b0;
		err_count           = 0;
		n_tests             = 0;
		cycles              = 0;
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;

		wait_cyc(45);
		check({15'h0, cal_active}, 16'h0001);
		wait_cyc(10);
		check({15'h0, cal_active}, 16'h0000);
		check({5'h0, offset_dac}, 16'h0020);
		rdc(REG_CTRL, 16'h0000);
		rdc(REG_GAIN, 16'h0000);
		rdc(8'h20, 16'h0000);
		wr(REG_CTRL, 16'h0001);
		wr(REG_CTRL, 16'h0000);
		wait_cyc(45);
		check({15'h0, cal_active}, 16'h0001);
		wait_cyc(10);
		check({15'h0, cal_active}, 16'h0000);
		$display("test calibration done");

		set_sample(10'h040);
		ob_line();
		check(black_fb, 16'hfff8);
		rdc(REG_STATUS, 16'h0004);
		wr(REG_LEADIN, 16'h0004);
		wr(REG_GAIN, 16'h0055);
		wait_cyc(2);
		check({15'h0, leadin_active}, 16'h0001);
		ob_line();
		check(black_fb, 16'hffd8);
		set_sample(10'h020);
		repeat (3) ob_line();
		check({15'h0, leadin_active}, 16'h0001);
		ob_line();
		check({15'h0, leadin_active}, 16'h0000);
		check(black_fb, 16'hffd8);
		wr(REG_GAIN, 16'h0055);
		wait_cyc(3);
		check({15'h0, leadin_active}, 16'h0000);
		$display("test feedback and lead-in done");

		for (int j = 0; j < 2; j++)
		begin
			for (int i = 0; i < 8; i++)
			begin
				set_sample(j ? 10'h3ff : 10'h200);
				wr(REG_CTRL, {10'h0, i[2:0], 3'h0});
				wait_cyc(2);
				check({6'h0, pin_level}, {6'h0, exp_code(adc_sample, i[2:0])});
			end
		end
		$display("test output coding done");

		@(posedge core_clk);
		preblank_input <= 1'b1;
		wr(REG_CTRL, 16'h003c);
		wait_cyc(4);
		check({6'h0, pin_level}, 16'h02aa);
		wr(REG_CTRL, 16'h0038);
		wait_cyc(4);
		check({6'h0, pin_level}, 16'h0020);
		check({15'h0, sample_isolate}, 16'h0001);
		wr(REG_CTRL, 16'h003e);
		wait_cyc(2);
		check({14'h0, floating, low_power}, 16'h0003);
		@(posedge core_clk);
		preblank_input <= 1'b0;
		wr(REG_CTRL, 16'h0000);
		wait_cyc(4);
		check({14'h0, floating, sample_isolate}, 16'h0000);
		$display("test output overrides done");

		wr(REG_CLAMP, 16'h0005);
		rdc(REG_CLAMP, 16'h000e);
		wr(REG_CLAMP, 16'h00ff);
		rdc(REG_CLAMP, 16'h004c);
		wr(REG_CLAMP, 16'h0030);
		wait_cyc(2);
		check({5'h0, offset_dac}, 16'h0030);
		$display("test clamp range done");

		// Error of 1 LSB: without lead-in the shift drops it; the x32 lead-in factor gives a step of 8
		set_sample(10'h031);
		wr(REG_LEADIN, 16'h0003);
		wr(REG_GAIN, 16'h00aa);
		ob_line();
		check(black_fb, 16'hffd0);
		check({15'h0, leadin_active}, 16'h0001);
		ob_line();
		check({15'h0, leadin_active}, 16'h0000);
		rdc(REG_FBVAL, 16'hffd0);
		$display("test largest lead-in factor done");

		// Sample above clamp for a whole run: result steps down once per cycle
		wr(REG_CTRL, 16'h0001);
		wr(REG_CTRL, 16'h0000);
		wait_cyc(60);
		rdc(REG_CALRES, 16'hffce);
		rdc(REG_DAC, 16'hfffe);
		$display("test calibration result done");
		finish_test();
	end
endmodule
